// file: logic/ddr_pkg.sv
// ddr_pkg: constants and carrier types for the display refresh dma block
// assumes a single 50 MHz clock and a synchronous active-high reset
package ddr_pkg;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // request interval and pulse widths in their own units
    localparam int unsigned REQ_PERIOD_US = 6000;
    localparam int unsigned HOLD_PULSE_US = 8;
    // interval derived from the clock rate
    localparam int unsigned REQ_PERIOD_CYC = REQ_PERIOD_US * CLK_MHZ;
    localparam int unsigned HOLD_PULSE_CYC = HOLD_PULSE_US * CLK_MHZ;
    // widths
    localparam int unsigned PAGE_W = 12;
    localparam int unsigned DIGIT_W = 4;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned UNIT_NUM = 4;
    localparam int unsigned POS_W = 2;
    localparam int unsigned PULSE_CNT_W = 9;
    localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;
    localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LAST = 9'(HOLD_PULSE_CYC - 1);

    // bus side signals towards the processor
    typedef struct packed {
        logic hold_request;
        logic [ADDR_W-1:0] addr;
        logic addr_oe;
    } ddr_bus_t;

    // one write towards the display units
    typedef struct packed {
        logic [UNIT_NUM-1:0] unit_sel;
        logic [POS_W-1:0] pos;
        logic [DATA_W-1:0] data;
        logic write_strobe;
    } ddr_disp_t;
endpackage : ddr_pkg

// file: logic/ddr_interval.sv
// ddr_interval: free-running request timer giving one tick per interval
// assumes the period count fits the counter width
module ddr_interval
    import ddr_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = REQ_PERIOD_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    output logic tick_out
);
    localparam int unsigned CW = $clog2(PERIOD_CYC);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt_r;
    wire at_end = (cnt_r == LAST);
    wire [CW-1:0] cnt_nxt = at_end ? ZERO : cnt_r + ONE;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_r <= ZERO;
            tick_out <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_out <= at_end;
        end
    end
endmodule : ddr_interval

// file: logic/ddr_strobe.sv
// ddr_strobe: turns the active-low memory read strobe into a late write pulse
// assumes the read strobe is synchronous to mclk_in
module ddr_strobe (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic window_in,
    input wire logic memory_read_strobe_n_in,
    output logic write_out
);
    logic rd_d_r;
    // pulse at the trailing edge of the read strobe, when data has settled
    wire rd_end = window_in & ~rd_d_r & memory_read_strobe_n_in;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_d_r <= 1'b1;
            write_out <= 1'b0;
        end else begin
            rd_d_r <= memory_read_strobe_n_in;
            write_out <= rd_end;
        end
    end
endmodule : ddr_strobe

// file: logic/ddr_refresh.sv
// ddr_refresh: periodic dma refresher for a sixteen-character display
// assumes a processor with hold handshake, synchronous to mclk_in
// Functional notes
// R01: a hold request is raised every 6 ms with no software involvement.
// R02: every granted hold moves exactly one character byte into one display unit.
// R03: the processor is suspended about 6 us per hold before the bus is released.
// R04: sixteen consecutive holds load all sixteen positions.
// R05: each hold request pulse lasts 8 us from its leading edge.
// R06: the processor acknowledges about 2 us after the hold request edge.
// R07: the transfer window is hold request and acknowledge together, ending with the request.
// R08: the address is driven only while acknowledge is active.
// R09: address upper 12 bits come from the preset switches, lower 4 from the digit counter.
// R10: the digit counter steps by one on each acknowledge pulse.
// R11: the display write is made from the read strobe once read data is valid.
// R12: a one-of-four decode enables exactly one display unit per write.
// R13: sixteen positions are spread over four units of four.
// R14: software keeps the characters at consecutive memory locations.
// R15: the counter width and request rate are parameters for larger displays; only PERIOD_CYC is a parameter, DIGIT_W is fixed in ddr_pkg.
// R16: a page step input advances the upper address bits for scrolling.
// R17: the digit counter wraps from fifteen to zero.
module ddr_refresh
    import ddr_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = REQ_PERIOD_CYC // [R15]
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [PAGE_W-1:0] page_switch_in,
    input wire logic page_step_in,
    input wire logic hold_acknowledge_in,
    input wire logic memory_read_strobe_n_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic hold_request_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe_out,
    output logic [UNIT_NUM-1:0] unit_sel_out,
    output logic [POS_W-1:0] pos_out,
    output logic [DATA_W-1:0] disp_data_out,
    output logic disp_write_out
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic {ST_IDLE, ST_HOLD} ddr_state_t;
    ddr_state_t state_r;
    logic [PULSE_CNT_W-1:0] pulse_cnt_r;
    logic [DIGIT_W-1:0] digit_r;
    logic [PAGE_W-1:0] page_off_r;
    logic ack_d_r;
    logic tick;
    logic wr_pulse;
    ddr_bus_t bus_r;
    ddr_disp_t disp_r;

    ddr_interval #(.PERIOD_CYC(PERIOD_CYC)) u_interval (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .tick_out(tick) // [R01]
    );

    ////////////////////////////////////////////////////////////////////
    // hold pulse timing
    wire pulse_done = (pulse_cnt_r == PULSE_LAST);
    wire window = bus_r.hold_request & hold_acknowledge_in; // [R07] [R03]
    wire ack_rise = hold_acknowledge_in & ~ack_d_r;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            pulse_cnt_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    pulse_cnt_r <= '0;
                    if (tick) begin
                        state_r <= ST_HOLD; // [R01]
                    end
                end
                ST_HOLD: begin
                    pulse_cnt_r <= pulse_cnt_r + 9'h001;
                    if (pulse_done) begin
                        state_r <= ST_IDLE; // [R05]
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address generation
    wire [PAGE_W-1:0] page = page_switch_in + page_off_r; // [R09] [R16]
    wire [ADDR_W-1:0] addr_nxt = {page, digit_r}; // [R09]

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            digit_r <= DIGIT_RST;
            page_off_r <= '0;
            ack_d_r <= 1'b0;
            bus_r <= '0;
        end else begin
            ack_d_r <= hold_acknowledge_in;
            if (ack_d_r & ~hold_acknowledge_in) begin
                digit_r <= digit_r + DIGIT_ONE; // [R10] [R17] [R04]
            end
            if (page_step_in) begin
                page_off_r <= page_off_r + 12'h001; // [R16]
            end
            // high for every hold state cycle, counts 0 to PULSE_LAST: 400 cycles
            bus_r.hold_request <= (state_r == ST_HOLD); // [R05]
            bus_r.addr <= addr_nxt;
            bus_r.addr_oe <= hold_acknowledge_in & ~ack_rise | ack_rise; // [R08]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display write path
    ddr_strobe u_strobe (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .window_in(window),
        .memory_read_strobe_n_in(memory_read_strobe_n_in),
        .write_out(wr_pulse) // [R11]
    );

    logic wr_done_r;
    wire [POS_W-1:0] unit_idx = digit_r[DIGIT_W-1:POS_W]; // [R13]
    wire [UNIT_NUM-1:0] unit_dec = 4'h1 << unit_idx; // [R12]
    wire wr_take = wr_pulse & ~wr_done_r; // [R02]

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            disp_r <= '0;
            wr_done_r <= 1'b0;
        end else begin
            if (!window) begin
                wr_done_r <= 1'b0;
            end else if (wr_pulse) begin
                wr_done_r <= 1'b1;
            end
            disp_r.write_strobe <= wr_take; // [R02]
            disp_r.unit_sel <= wr_take ? unit_dec : 4'h0; // [R12]
            if (wr_take) begin
                disp_r.pos <= digit_r[POS_W-1:0];
                disp_r.data <= data_in;
            end
        end
    end

    assign hold_request_out = bus_r.hold_request;
    assign addr_out = bus_r.addr;
    assign addr_oe_out = bus_r.addr_oe;
    assign unit_sel_out = disp_r.unit_sel;
    assign pos_out = disp_r.pos;
    assign disp_data_out = disp_r.data;
    assign disp_write_out = disp_r.write_strobe;
endmodule : ddr_refresh

// file: bench/ddr_refresh_assertions.sv
// ddr_refresh_assertions: port timing checks for the refresh block
// assumes one clock and a synchronous active-high reset
module ddr_refresh_checker
    import ddr_pkg::*;
#(parameter int unsigned PERIOD_CYC = REQ_PERIOD_CYC) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic hold_acknowledge_in,
    input wire logic memory_read_strobe_n_in,
    input wire logic hold_request_out,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic addr_oe_out,
    input wire logic [UNIT_NUM-1:0] unit_sel_out,
    input wire logic [POS_W-1:0] pos_out,
    input wire logic disp_write_out
);
    logic [15:0] hi_r;
    logic [31:0] gap_r;
    logic seen_r;
    logic [DIGIT_W-1:0] dig_r;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    //////////////////////////////
    // dig_r starts at f so the first fetch must be digit 0
    always_ff @(posedge mclk_in) begin
        hi_r <= rst_in ? 16'h0 : (hold_request_out ? hi_r + 16'h1 : 16'h0);
        gap_r <= $rose(hold_request_out) ? 32'h1 : gap_r + 32'h1;
        seen_r <= !rst_in && (seen_r || $rose(hold_request_out));
        dig_r <= rst_in ? 4'hf : ($rose(addr_oe_out) ? addr_out[3:0] : dig_r);
    end
    a_req_width_cap: assert property (hold_request_out |-> hi_r < HOLD_PULSE_CYC)
        else $error("request too long");
    a_req_width_end: assert property ($fell(hold_request_out) |-> hi_r == HOLD_PULSE_CYC)
        else $error("request width wrong");
    a_req_period_gap: assert property ($rose(hold_request_out) && seen_r |-> gap_r == PERIOD_CYC)
        else $error("request interval wrong");
    a_oe_ack_rise: assert property ($rose(hold_acknowledge_in) |=> addr_oe_out)
        else $error("address not driven");
    a_oe_ack_low: assert property (!hold_acknowledge_in |=> !addr_oe_out)
        else $error("address driven without grant");
    a_digit_step_one: assert property ($rose(addr_oe_out) |-> addr_out[3:0] == dig_r + 4'h1)
        else $error("digit did not step by one");
    a_unit_decode_one: assert property (disp_write_out |-> unit_sel_out == (4'h1 << addr_out[3:2]) && pos_out == addr_out[1:0])
        else $error("unit decode wrong");
    a_unit_idle_zero: assert property (!disp_write_out |-> unit_sel_out == 4'h0)
        else $error("unit enabled without write");
    a_write_in_window: assert property (disp_write_out |-> hold_request_out && addr_oe_out)
        else $error("write outside window");
    a_write_after_read: assert property ($rose(memory_read_strobe_n_in) && hold_acknowledge_in |-> ##[1:3] disp_write_out)
        else $error("no write after read");
endmodule : ddr_refresh_checker
bind ddr_refresh ddr_refresh_checker #(.PERIOD_CYC(PERIOD_CYC)) u_chk (.mclk_in(mclk_in),
    .rst_in(rst_in), .hold_acknowledge_in(hold_acknowledge_in),
    .memory_read_strobe_n_in(memory_read_strobe_n_in), .hold_request_out(hold_request_out),
    .addr_out(addr_out), .addr_oe_out(addr_oe_out), .unit_sel_out(unit_sel_out),
    .pos_out(pos_out), .disp_write_out(disp_write_out));

// file: bench/ddr_cpu_model.sv
// ddr_cpu_model: processor side, grants the hold and serves one read
// assumes the bench changes slow_in at the falling edge
module ddr_cpu_model
    import ddr_pkg::*;
(
    input wire logic mclk_in,
    input wire logic slow_in,
    input wire logic hold_request_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic addr_oe_in,
    output logic hold_acknowledge_out,
    output logic memory_read_strobe_n_out,
    output logic [DATA_W-1:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial begin
        hold_acknowledge_out = 1'b0;
        memory_read_strobe_n_out = 1'b1;
        data_out = 8'h00;
    end
    //////////////////////////////
    // idle data bus toggles so a stale byte never looks valid
    always @(negedge mclk_in) begin
        cnt = hold_request_in ? cnt + 1 : 0;
        hold_acknowledge_out <= hold_request_in && cnt > (slow_in ? 150 : 100);
        memory_read_strobe_n_out <= !(addr_oe_in && cnt > 200 && cnt < 221);
        data_out <= (addr_oe_in && cnt > 200 && cnt < 225) ? addr_in[7:0] + 8'h30 : ~data_out;
    end
endmodule : ddr_cpu_model

// file: bench/test_ddr_refresh.sv
// test_ddr_refresh: refresh block against the processor model
// assumes a 50 MHz clock and a shortened request interval
module test_ddr_refresh;
    import ddr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [PAGE_W-1:0] page = 12'h2a5;
    logic [PAGE_W-1:0] off = 12'h000;
    logic step = 1'b0;
    logic slow = 1'b0;
    logic stray_n = 1'b1;
    logic ack, rd_n, cpu_rd_n, req, oe, wr;
    logic [DATA_W-1:0] din, dout;
    logic [ADDR_W-1:0] addr;
    logic [UNIT_NUM-1:0] unit;
    logic [POS_W-1:0] pos;
    logic [DIGIT_W-1:0] dig = 4'h0;
    int mismatches = 0;
    int tests_run = 0;
    assign rd_n = cpu_rd_n & stray_n;
    always #10 mclk_in = ~mclk_in;
    ddr_refresh #(.PERIOD_CYC(1000)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
        .page_switch_in(page), .page_step_in(step), .hold_acknowledge_in(ack),
        .memory_read_strobe_n_in(rd_n), .data_in(din), .hold_request_out(req), .addr_out(addr),
        .addr_oe_out(oe), .unit_sel_out(unit), .pos_out(pos), .disp_data_out(dout),
        .disp_write_out(wr));
    ddr_cpu_model cpu (.mclk_in(mclk_in), .slow_in(slow), .hold_request_in(req),
        .addr_in(addr), .addr_oe_in(oe), .hold_acknowledge_out(ack),
        .memory_read_strobe_n_out(cpu_rd_n), .data_out(din));
    //////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : cyc
    // one granted hold: address, unit, position and byte of the next digit
    task automatic xfer();
        int n = 0;
        logic [PAGE_W-1:0] pg = page + off;
        while (wr !== 1'b1 && n < 1500) begin
            cyc(1);
            n++;
        end
        check(16'(wr), 16'h1);
        check(addr, {pg, dig});
        check(16'(unit), 16'(4'h1 << dig[3:2]));
        check(16'(pos), 16'(dig[1:0]));
        check(16'(dout), 16'(8'h30 + {pg[3:0], dig}));
        cyc(1);
        check(16'(wr), 16'h0);
        dig++;
        n = 0;
        while (req !== 1'b0 && n < 1000) begin
            cyc(1);
            n++;
        end
    endtask : xfer
    task automatic t_reset();
        check(16'({req, oe, wr, unit}), 16'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_cycle();
        for (int i = 0; i < 17; i++) begin
            slow = i[0];
            xfer();
        end
        $display("test cycle done");
    endtask : t_cycle
    task automatic t_stray();
        stray_n = 1'b0;
        cyc(5);
        stray_n = 1'b1;
        repeat (20) begin
            cyc(1);
            check(16'({oe, wr, unit}), 16'h0);
        end
        xfer();
        $display("test stray done");
    endtask : t_stray
    task automatic t_page();
        step = 1'b1;
        cyc(1);
        step = 1'b0;
        off++;
        xfer();
        $display("test page done");
    endtask : t_page
    initial begin
        cyc(6);
        rst_in = 1'b0;
        cyc(1);
        t_reset();
        t_cycle();
        t_stray();
        t_page();
        test_done();
    end
    initial begin
        #(40000 * 20);
        mismatches++;
        test_done();
    end
endmodule : test_ddr_refresh
